// ### rtl/oe_refsel_params.svh
`ifndef OE_REFSEL_PARAMS_SVH
`define OE_REFSEL_PARAMS_SVH
`define REG_PIN_READBACK_ADDR 8'h02
`define REG_ADDR_W            8
`define REG_DATA_W            24
`define BIT_EN4               15
`define BIT_OVR4              14
`define BIT_EN3               13
`define BIT_OVR3              12
`define BIT_EN2               11
`define BIT_OVR2              10
`define BIT_EN1               9
`define BIT_OVR1              8
`define BIT_SRC2              7
`define BIT_SRC2_EN           6
`define BIT_SRC1              5
`define BIT_SRC1_EN           4
`define BIT_PLL2              3
`define BIT_PLL2_EN           2
`define RESET_BIT             1'b0
`define REF_PRIMARY           1'b0
`endif

// ### rtl/oe_refsel_pkg.sv
package oe_refsel_pkg;
  // Register strobe bundle
  typedef struct packed {
    logic [7:0]  addr;
    logic [23:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;
  // Driver enables, lowest index is the first output
  typedef logic [3:0] drv_vec_t;
endpackage

// ### rtl/oe_override_slice.sv
`include "oe_refsel_params.svh"
// One output: override latch plus pin fallback
module oe_override_slice
  import oe_refsel_pkg::*;
(
  input  wire logic sys_clk,    // Register clock
  input  wire logic sys_rst,    // Async reset, high
  input  wire logic wrEn,       // Register write this cycle
  input  wire logic wrOvr,      // Written override bit
  input  wire logic wrVal,      // Written enable bit
  input  wire logic pinLevel,   // External enable pin
  output logic      ovrBit,     // Override bit readback
  output logic      enBit,      // Enable bit readback
  output logic      driveReq    // Requested driver state
);
  logic ovr_r;
  logic val_r;

  // Override and value bits, both reset to 0
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ovr_r <= `RESET_BIT;
    else if (wrEn)
      ovr_r <= wrOvr;
  end

  // writes gated by override
  // Written value only lands when the same write leaves override set
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      val_r <= `RESET_BIT;
    else if (wrEn && wrOvr)
      val_r <= wrVal;
  end

  assign ovrBit   = ovr_r;
  assign enBit    = ovr_r ? val_r : pinLevel;
  assign driveReq = enBit;
endmodule

// ### rtl/ref_choice_slice.sv
`include "oe_refsel_params.svh"
// One PLL reference choice with its enable
module ref_choice_slice
  import oe_refsel_pkg::*;
(
  input  wire logic sys_clk,    // Register clock
  input  wire logic sys_rst,    // Async reset, high
  input  wire logic wrEn,       // Register write this cycle
  input  wire logic wrSelEn,    // Written select enable
  input  wire logic wrSel,      // Written select
  output logic      selEnBit,   // Select enable readback
  output logic      selBit,     // Select readback
  output logic      useSecond   // 1 selects secondary reference
);
  logic selEn_r;
  logic sel_r;

  // Both bits stored plainly, reset 0
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      selEn_r <= `RESET_BIT;
      sel_r   <= `RESET_BIT;
    end
    else if (wrEn)
    begin
      selEn_r <= wrSelEn;
      sel_r   <= wrSel;
    end
  end

  assign useSecond = selEn_r ? sel_r : `REF_PRIMARY;
  assign selEnBit  = selEn_r;
  assign selBit    = sel_r;
endmodule

// ### rtl/output_enable_refsel_override.sv
`include "oe_refsel_params.svh"
// Pin readback / override register, bits 15..2
module output_enable_refsel_override
  import oe_refsel_pkg::*;
(
  input  wire logic        sys_clk,           // 40 MHz register clock
  input  wire logic        sys_rst,           // Async reset, high
  input  wire logic [7:0]  regAddr,           // Register address
  input  wire logic [23:0] regWdata,          // Write data
  input  wire logic        regWr,             // Write strobe
  input  wire logic        regRd,             // Read strobe
  output logic      [23:0] regRdata,          // Read data, cycle after strobe
  input  wire logic        firstEnablePin,    // First output enable pin
  input  wire logic        secondEnablePin,   // Second output enable pin
  input  wire logic        thirdEnablePin,    // Third output enable pin
  input  wire logic        fourthEnablePin,   // Fourth output enable pin
  output logic             firstDriverOn,     // First driver enabled
  output logic             secondDriverOn,    // Second driver enabled
  output logic             thirdDriverOn,     // Third driver enabled
  output logic             fourthDriverOn,    // Fourth driver enabled
  output logic             firstPllRefChoice, // 1: secondary ref for first PLL
  output logic             secondPllRefChoice,// 1: secondary ref for second PLL
  output logic             secondPllRun       // Second PLL powered and enabled
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  reg_req_t req;
  logic     hit;
  logic     wrHit;

  assign req   = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
  assign hit   = (req.addr == `REG_PIN_READBACK_ADDR);
  assign wrHit = req.wr && hit;

  ////////////////////////////////////////////////////////////////////////////
  // Output enable slices
  drv_vec_t pins;
  drv_vec_t ovrBits;
  drv_vec_t enBits;
  drv_vec_t driveReq;

  assign pins = {fourthEnablePin, thirdEnablePin, secondEnablePin, firstEnablePin};

  oe_override_slice u_drv1 (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .wrEn     (wrHit),
    .wrOvr    (req.wdata[`BIT_OVR1]),
    .wrVal    (req.wdata[`BIT_EN1]),
    .pinLevel (pins[0]),
    .ovrBit   (ovrBits[0]),
    .enBit    (enBits[0]),
    .driveReq (driveReq[0])
  );

  oe_override_slice u_drv2 (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .wrEn     (wrHit),
    .wrOvr    (req.wdata[`BIT_OVR2]),
    .wrVal    (req.wdata[`BIT_EN2]),
    .pinLevel (pins[1]),
    .ovrBit   (ovrBits[1]),
    .enBit    (enBits[1]),
    .driveReq (driveReq[1])
  );

  oe_override_slice u_drv3 (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .wrEn     (wrHit),
    .wrOvr    (req.wdata[`BIT_OVR3]),
    .wrVal    (req.wdata[`BIT_EN3]),
    .pinLevel (pins[2]),
    .ovrBit   (ovrBits[2]),
    .enBit    (enBits[2]),
    .driveReq (driveReq[2])
  );

  oe_override_slice u_drv4 (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .wrEn     (wrHit),
    .wrOvr    (req.wdata[`BIT_OVR4]),
    .wrVal    (req.wdata[`BIT_EN4]),
    .pinLevel (pins[3]),
    .ovrBit   (ovrBits[3]),
    .enBit    (enBits[3]),
    .driveReq (driveReq[3])
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reference choice slices
  logic sel1En;
  logic sel1;
  logic use1Second;
  logic sel2En;
  logic sel2;
  logic use2Second;

  ref_choice_slice u_ref1 (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .wrEn      (wrHit),
    .wrSelEn   (req.wdata[`BIT_SRC1_EN]),
    .wrSel     (req.wdata[`BIT_SRC1]),
    .selEnBit  (sel1En),
    .selBit    (sel1),
    .useSecond (use1Second)
  );

  ref_choice_slice u_ref2 (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .wrEn      (wrHit),
    .wrSelEn   (req.wdata[`BIT_SRC2_EN]),
    .wrSel     (req.wdata[`BIT_SRC2]),
    .selEnBit  (sel2En),
    .selBit    (sel2),
    .useSecond (use2Second)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Second PLL power control
  logic pll2En_r;
  logic pll2_r;
  logic pll2Run;

  // Both bits plain storage, reset 0
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pll2En_r <= `RESET_BIT;
      pll2_r   <= `RESET_BIT;
    end
    else if (wrHit)
    begin
      pll2En_r <= req.wdata[`BIT_PLL2_EN];
      pll2_r   <= req.wdata[`BIT_PLL2];
    end
  end

  assign pll2Run = pll2En_r && pll2_r;

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  // drivers gated by second PLL
  // Drivers follow pin a cycle late; fine for static enables
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      firstDriverOn  <= `RESET_BIT;
      secondDriverOn <= `RESET_BIT;
      thirdDriverOn  <= `RESET_BIT;
      fourthDriverOn <= `RESET_BIT;
    end
    else
    begin
      firstDriverOn  <= driveReq[0] && pll2Run;
      secondDriverOn <= driveReq[1] && pll2Run;
      thirdDriverOn  <= driveReq[2] && pll2Run;
      fourthDriverOn <= driveReq[3] && pll2Run;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      firstPllRefChoice  <= `REF_PRIMARY;
      secondPllRefChoice <= `REF_PRIMARY;
      secondPllRun       <= `RESET_BIT;
    end
    else
    begin
      firstPllRefChoice  <= use1Second;
      secondPllRefChoice <= use2Second;
      secondPllRun       <= pll2Run;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: data only in the cycle after the strobe
  logic [23:0] rdImage;

  always_comb
  begin
    rdImage                  = '0;
    rdImage[`BIT_EN4]        = enBits[3];
    rdImage[`BIT_OVR4]       = ovrBits[3];
    rdImage[`BIT_EN3]        = enBits[2];
    rdImage[`BIT_OVR3]       = ovrBits[2];
    rdImage[`BIT_EN2]        = enBits[1];
    rdImage[`BIT_OVR2]       = ovrBits[1];
    rdImage[`BIT_EN1]        = enBits[0];
    rdImage[`BIT_OVR1]       = ovrBits[0];
    rdImage[`BIT_SRC2]       = sel2;
    rdImage[`BIT_SRC2_EN]    = sel2En;
    rdImage[`BIT_SRC1]       = sel1;
    rdImage[`BIT_SRC1_EN]    = sel1En;
    rdImage[`BIT_PLL2]       = pll2_r;
    rdImage[`BIT_PLL2_EN]    = pll2En_r;
  end

  // Unmapped or idle reads return zero
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      regRdata <= '0;
    else if (req.rd && hit)
      regRdata <= rdImage;
    else
      regRdata <= '0;
  end
endmodule

// ### testbench/oe_refsel_checker_props.sv
// Watches the register block from its ports only
module oe_refsel_checker
  import oe_refsel_pkg::*;
(
  input wire logic        sys_clk,            // Clock
  input wire logic        sys_rst,            // Async reset, high
  input wire logic [7:0]  regAddr,            // Address
  input wire logic [23:0] regWdata,           // Write data
  input wire logic        regWr,              // Write strobe
  input wire logic        regRd,              // Read strobe
  input wire logic [23:0] regRdata,           // Read data
  input wire logic        firstEnablePin,     // First pin
  input wire logic        fourthEnablePin,    // Fourth pin
  input wire logic        firstDriverOn,      // First driver
  input wire logic        secondDriverOn,     // Second driver
  input wire logic        thirdDriverOn,      // Third driver
  input wire logic        fourthDriverOn,     // Fourth driver
  input wire logic        firstPllRefChoice,  // First PLL reference
  input wire logic        secondPllRefChoice, // Second PLL reference
  input wire logic        secondPllRun        // Second PLL running
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Read port: data only right after a strobe, holes read zero
  property p_rdIdle;
    !$past(regRd) |-> regRdata == 24'h000000;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside read slot");
  property p_unmapped;
    $past(regRd) && $past(regAddr) != 8'h02 |-> regRdata == 24'h000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rsvd;
    $past(regRd) |-> regRdata[23:16] == 8'h00 && regRdata[1:0] == 2'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("unused bits not zero");
  // Pin level seen in the image while not overridden
  property p_pin4;
    $past(regRd) && $past(regAddr) == 8'h02 && !regRdata[14]
      |-> regRdata[15] == $past(fourthEnablePin);
  endproperty
  a_pin4: assert property (p_pin4) else $error("fourth pin readback wrong");
  property p_pin1;
    $past(regRd) && $past(regAddr) == 8'h02 && !regRdata[8]
      |-> regRdata[9] == $past(firstEnablePin);
  endproperty
  a_pin1: assert property (p_pin1) else $error("first pin readback wrong");
  // Drivers and PLL state leave the same register stage, so no slack
  property p_gate4;
    fourthDriverOn |-> secondPllRun;
  endproperty
  a_gate4: assert property (p_gate4) else $error("fourth on without PLL");
  property p_gate13;
    firstDriverOn || secondDriverOn || thirdDriverOn |-> secondPllRun;
  endproperty
  a_gate13: assert property (p_gate13) else $error("driver on without PLL");
  // Reference and PLL state move only after a write
  property p_refHold;
    !$past(regWr) && !$past(regWr, 2) && !$past(regWr, 3)
      |-> $stable({firstPllRefChoice, secondPllRefChoice, secondPllRun});
  endproperty
  a_refHold: assert property (p_refHold) else $error("state moved without write");
  // Mapped write shows on the outputs two edges after its strobe
  property p_pll2;
    $past(regWr, 2) && $past(regAddr, 2) == 8'h02
      |-> secondPllRun == ($past(regWdata[3], 2) && $past(regWdata[2], 2));
  endproperty
  a_pll2: assert property (p_pll2) else $error("second PLL state wrong");
  property p_ref1;
    $past(regWr, 2) && $past(regAddr, 2) == 8'h02
      |-> firstPllRefChoice == ($past(regWdata[5], 2) && $past(regWdata[4], 2));
  endproperty
  a_ref1: assert property (p_ref1) else $error("first reference choice wrong");
endmodule
bind output_enable_refsel_override oe_refsel_checker chk_i (.*);

// ### testbench/enable_pin_source.sv
// External logic driving the four enable pins
module enable_pin_source
  import oe_refsel_pkg::*;
(
  input  wire logic     sys_clk, // Clock
  input  wire drv_vec_t want,    // Requested levels
  output drv_vec_t      pins     // Enable pins, first is bit 0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Registered so pins never move at the sampling instant
  always_ff @(posedge sys_clk)
    pins <= want;
endmodule

// ### testbench/output_enable_refsel_override_tb.sv
module output_enable_refsel_override_tb
  import oe_refsel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [23:0] regWdata = 24'h000000;
  logic [23:0] regRdata;
  logic [23:0] mReg = 24'h000000; // Expected stored bits
  drv_vec_t    pinWant = 4'h0;
  drv_vec_t    pins;
  drv_vec_t    drv;
  logic        ref1;
  logic        ref2;
  logic        run;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  output_enable_refsel_override dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .firstEnablePin(pins[0]), .secondEnablePin(pins[1]), .thirdEnablePin(pins[2]),
    .fourthEnablePin(pins[3]), .firstDriverOn(drv[0]), .secondDriverOn(drv[1]),
    .thirdDriverOn(drv[2]), .fourthDriverOn(drv[3]), .firstPllRefChoice(ref1),
    .secondPllRefChoice(ref2), .secondPllRun(run));
  enable_pin_source pinSrc (.sys_clk(sys_clk), .want(pinWant), .pins(pins));
  initial
    forever #12.5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Enable bit only lands with its override in the same write
  task automatic regWrite(input logic [7:0] a, input logic [23:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
    if (a == 8'h02)
    begin
      mReg[7:2] = d[7:2];
      for (int i = 8; i < 16; i += 2)
      begin
        mReg[i] = d[i];
        if (d[i])
          mReg[i + 1] = d[i + 1];
      end
    end
  endtask
  task automatic regRead(input logic [7:0] a, output logic [23:0] d);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  // Image and ports against the model
  task automatic checkState();
    logic [23:0] d;
    logic [23:0] e;
    logic [3:0]  de;
    e = {16'h0000, mReg[7:2], 2'b00};
    for (int i = 0; i < 4; i++)
      e[9 + 2 * i -: 2] = {mReg[8 + 2 * i] ? mReg[9 + 2 * i] : pinWant[i], mReg[8 + 2 * i]};
    de = {e[15], e[13], e[11], e[9]} & {4{mReg[3] & mReg[2]}};
    @(posedge sys_clk);
    regRead(8'h02, d);
    chk(d, e);
    chk({17'h0, run, ref2, ref1, drv},
        {17'h0, mReg[3] & mReg[2], mReg[7] & mReg[6], mReg[5] & mReg[4], de});
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the roughly 160 cycles of the run
  initial
  begin
    repeat (4000) @(posedge sys_clk);
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    logic [23:0] d;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    checkState();
    pinWant = 4'b1010;
    checkState();
    regWrite(8'h02, 24'h000008);
    checkState();
    // Software must start the second PLL first
    regWrite(8'h02, 24'h00000c);
    checkState();
    pinWant = 4'b0101;
    regWrite(8'h02, 24'h00aa0c);
    checkState();
    // Override each output against the opposite pin level
    for (int i = 0; i < 4; i++)
    begin
      pinWant = 4'h0;
      regWrite(8'h02, 24'h00000c | (24'h000003 << (8 + 2 * i)));
      checkState();
      pinWant = 4'hf;
      regWrite(8'h02, 24'h00000c | (24'h000001 << (8 + 2 * i)));
      checkState();
    end
    regWrite(8'h02, 24'h00ff08);
    checkState();
    for (int j = 0; j < 16; j++)
    begin
      regWrite(8'h02, {16'h0000, j[3:0], 4'hc});
      checkState();
    end
    // Unmapped address neither stores nor answers
    regWrite(8'h03, 24'hffffff);
    regRead(8'h03, d);
    chk(d, 24'h000000);
    checkState();
    report_and_stop();
  end
endmodule
